// ==== hw/asc_cfg.svh ====
// constants for the analog sync and control register bank
// How it works
// - pulse leads on phase adjusted feedback clock
// - pulse lasts pulse width minus one clocks
// - per channel 8-bit gain, 255 is 1.0 V
// - 7-bit offset word in bits 7-1
// - separator toggles after threshold plus one 5 MHz ticks
// - 5-bit slicer level, 10 mV steps, reset 15
// - interface override bit forces select bit
// - select bit: 0 analog, 1 digital, ties
// - polarity override takes polarity from bit 6
// - polarity picks timing edge, other edge times the clamp
// - wrong polarity still works, clamp misplaced
// - output polarity bit sets line and green sync
// - line sync source override and select bits
// - frame sync out: 1 passes, 0 inverts
// - frame sync source override and select bits
// - clamp function bit 7 at 0 enables internal clamp
// - clamp starts placement clocks after trailing edge
`ifndef ASC_CFG_SVH
`define ASC_CFG_SVH

`define ASC_ADDR_PW        8'h07
`define ASC_ADDR_GAIN_R    8'h08
`define ASC_ADDR_GAIN_G    8'h09
`define ASC_ADDR_GAIN_B    8'h0A
`define ASC_ADDR_OFS_R     8'h0B
`define ASC_ADDR_OFS_G     8'h0C
`define ASC_ADDR_OFS_B     8'h0D
`define ASC_ADDR_SEP_THR   8'h0E
`define ASC_ADDR_SLICER    8'h0F
`define ASC_ADDR_SYNC_CTL  8'h10
`define ASC_ADDR_CLAMP_CTL 8'h11

`define ASC_RST_PW         8'h20
`define ASC_RST_GAIN       8'h80
`define ASC_RST_OFS        8'h80
`define ASC_RST_SEP_THR    8'h20
`define ASC_RST_SLICER     8'h78
`define ASC_RST_SYNC_CTL   8'h40
`define ASC_RST_CLAMP_CTL  8'h08

// field positions
`define ASC_OFS_MSB        7
`define ASC_OFS_LSB        1
`define ASC_SLICER_MSB     7
`define ASC_SLICER_LSB     3
`define ASC_BIT_IF_OVR     2
`define ASC_BIT_IF_SEL     1
`define ASC_BIT_HPOL_OVR   7
`define ASC_BIT_HPOL       6
`define ASC_BIT_HOUT_POL   5
`define ASC_BIT_HSRC_OVR   4
`define ASC_BIT_HSRC_SEL   3
`define ASC_BIT_VOUT_POL   2
`define ASC_BIT_VSRC_OVR   1
`define ASC_BIT_VSRC_SEL   0
`define ASC_BIT_CLAMP_OFF  7

// pin vector positions
`define ASC_PIN_HS         0
`define ASC_PIN_SOG        1
`define ASC_PIN_VS         2
`define ASC_PIN_DIG        3
`define ASC_PIN_SEP        3

// timing
`define ASC_PIX_CLK_HZ     25000000
`define ASC_SEP_CLK_HZ     5000000
`define ASC_SEP_DIV        (`ASC_PIX_CLK_HZ / `ASC_SEP_CLK_HZ)
`define ASC_SEP_DIV_LAST   3'(`ASC_SEP_DIV - 1)
`define ASC_ACT_TIMEOUT    65535
`define ASC_POL_MID        8'h80
`define ASC_POL_MAX        8'hFF

`endif

// ==== hw/asc_pkg.sv ====
// types shared by the analog sync and control register bank
package asc_pkg;
	typedef enum logic [1:0] {
		ASC_CL_IDLE = 2'b00,
		ASC_CL_WAIT = 2'b01,
		ASC_CL_ON   = 2'b10
	} asc_clamp_e;

	typedef struct packed {
		logic [7:0] cnt;
		logic       out;
	} asc_sep_s;
endpackage

// ==== hw/asc_sync_sep.sv ====
// sync separator: low-pass filter that pulls frame sync from composite sync
`timescale 1ns/1ps
`include "asc_cfg.svh"
module asc_sync_sep
	import asc_pkg::*;
(
	input  wire logic       sys_clk_in,
	input  wire logic       rst_in,
	input  wire logic       tick_in,
	input  wire logic       sync_in,
	input  wire logic [7:0] thr_in,
	output logic            sep_out
);
	asc_sep_s st_r;
	asc_sep_s st_nxt;

	always_comb begin
		st_nxt = st_r;
		if (sync_in == st_r.out) begin
			st_nxt.cnt = 8'h00;
		end else if (tick_in) begin
			// short line pulses never reach the threshold and are dropped
			if (st_r.cnt >= thr_in) begin
				st_nxt.out = sync_in;
				st_nxt.cnt = 8'h00;
			end else begin
				st_nxt.cnt = st_r.cnt + 8'h01;
			end
		end
	end

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign sep_out = st_r.out;
endmodule // asc_sync_sep

// ==== hw/asc_regs.sv ====
// analog sync processing and control register bank, pixel clock domain
`timescale 1ns/1ps
`include "asc_cfg.svh"
module asc_regs
	import asc_pkg::*;
#(
	parameter logic [15:0] ACT_TIMEOUT_CYC = 16'(`ASC_ACT_TIMEOUT)
) (
	input  wire logic       sys_clk_in,
	input  wire logic       rst_in,
	input  wire logic       reg_wr_in,
	input  wire logic       reg_rd_in,
	input  wire logic [7:0] reg_addr_in,
	input  wire logic [7:0] reg_wdata_in,
	output logic      [7:0] reg_rdata_out,
	input  wire logic       pll_fb_in,
	input  wire logic       hsync_in,
	input  wire logic       sync_on_green_in,
	input  wire logic       vsync_in,
	input  wire logic       digital_detect_in,
	input  wire logic [7:0] clamp_placement_in,
	input  wire logic [7:0] clamp_duration_in,
	output logic            hsync_out,
	output logic            sync_on_green_out,
	output logic            vsync_out,
	output logic            clamp_out,
	output logic            interface_digital_out,
	output logic            hsync_src_sog_out,
	output logic            vsync_src_sep_out,
	output logic            line_sync_polarity_out,
	output logic      [7:0] red_channel_gain_out,
	output logic      [7:0] green_channel_gain_out,
	output logic      [7:0] blue_channel_gain_out,
	output logic      [6:0] red_channel_offset_out,
	output logic      [6:0] green_channel_offset_out,
	output logic      [6:0] blue_channel_offset_out,
	output logic      [4:0] slicer_threshold_out
);
	typedef struct packed {
		logic [7:0]       pw;
		logic [7:0]       gain_r;
		logic [7:0]       gain_g;
		logic [7:0]       gain_b;
		logic [7:0]       ofs_r;
		logic [7:0]       ofs_g;
		logic [7:0]       ofs_b;
		logic [7:0]       sep_thr;
		logic [7:0]       slicer;
		logic [7:0]       sync_ctl;
		logic [7:0]       clamp_ctl;
		logic [7:0]       rdata;
		logic [3:0]       sy1;
		logic [3:0]       sy2;
		logic [3:0]       prev;
		logic [3:0][15:0] act_cnt;
		logic [7:0]       pol_cnt;
		logic             norm_prev;
		logic             hs_act;
		logic [7:0]       hs_cnt;
		asc_clamp_e       clamp_st;
		logic [7:0]       clamp_cnt;
		logic             clamp;
		logic [2:0]       div;
		logic             tick;
		logic             hs_o;
		logic             sog_o;
		logic             vs_o;
		logic             if_dig;
		logic             hsrc_sog;
		logic             vsrc_sep;
		logic             pol;
	} asc_state_s;

	asc_state_s st_r;
	asc_state_s st_nxt;
	logic       sep_w;
	logic       sep_in_w;

	// auto choice: a lone active candidate wins, otherwise the select bit
	function automatic logic pick_src(input logic ovr, input logic sel,
		input logic act_a, input logic act_b);
		logic res;
		res = sel;
		if (!ovr) begin
			if (act_a && !act_b) begin
				res = 1'b0;
			end else if (act_b && !act_a) begin
				res = 1'b1;
			end
		end
		return res;
	endfunction

	asc_sync_sep u_sep (
		.sys_clk_in (sys_clk_in),
		.rst_in     (rst_in),
		.tick_in    (st_r.tick),
		.sync_in    (sep_in_w),
		.thr_in     (st_r.sep_thr),
		.sep_out    (sep_w)
	);

	always_comb begin
		logic [3:0] edges;
		logic       hs_s;
		logic       sog_s;
		logic       norm;
		logic       trail;
		logic       pol_det;
		logic [7:0] load;
		edges   = '0;
		hs_s    = 1'b0;
		sog_s   = 1'b0;
		norm    = 1'b0;
		trail   = 1'b0;
		pol_det = 1'b0;
		load    = '0;
		st_nxt  = st_r;

		// register writes; unmapped offsets are ignored
		if (reg_wr_in) begin
			case (reg_addr_in)
				`ASC_ADDR_PW:        st_nxt.pw = reg_wdata_in;
				`ASC_ADDR_GAIN_R:    st_nxt.gain_r = reg_wdata_in;
				`ASC_ADDR_GAIN_G:    st_nxt.gain_g = reg_wdata_in;
				`ASC_ADDR_GAIN_B:    st_nxt.gain_b = reg_wdata_in;
				`ASC_ADDR_OFS_R:     st_nxt.ofs_r = reg_wdata_in;
				`ASC_ADDR_OFS_G:     st_nxt.ofs_g = reg_wdata_in;
				`ASC_ADDR_OFS_B:     st_nxt.ofs_b = reg_wdata_in;
				`ASC_ADDR_SEP_THR:   st_nxt.sep_thr = reg_wdata_in;
				`ASC_ADDR_SLICER:    st_nxt.slicer = reg_wdata_in;
				`ASC_ADDR_SYNC_CTL:  st_nxt.sync_ctl = reg_wdata_in;
				`ASC_ADDR_CLAMP_CTL: st_nxt.clamp_ctl = reg_wdata_in;
				default:             st_nxt.pw = st_r.pw;
			endcase
		end
		if (reg_rd_in) begin
			case (reg_addr_in)
				`ASC_ADDR_PW:        st_nxt.rdata = st_r.pw;
				`ASC_ADDR_GAIN_R:    st_nxt.rdata = st_r.gain_r;
				`ASC_ADDR_GAIN_G:    st_nxt.rdata = st_r.gain_g;
				`ASC_ADDR_GAIN_B:    st_nxt.rdata = st_r.gain_b;
				`ASC_ADDR_OFS_R:     st_nxt.rdata = st_r.ofs_r;
				`ASC_ADDR_OFS_G:     st_nxt.rdata = st_r.ofs_g;
				`ASC_ADDR_OFS_B:     st_nxt.rdata = st_r.ofs_b;
				`ASC_ADDR_SEP_THR:   st_nxt.rdata = st_r.sep_thr;
				`ASC_ADDR_SLICER:    st_nxt.rdata = st_r.slicer;
				`ASC_ADDR_SYNC_CTL:  st_nxt.rdata = st_r.sync_ctl;
				`ASC_ADDR_CLAMP_CTL: st_nxt.rdata = st_r.clamp_ctl;
				default:             st_nxt.rdata = 8'h00;
			endcase
		end

		// pin synchronisers; only the second stage is looked at
		st_nxt.sy1 = {digital_detect_in, vsync_in, sync_on_green_in,
			hsync_in};
		st_nxt.sy2 = st_r.sy1;
		hs_s  = st_r.sy2[`ASC_PIN_HS];
		sog_s = st_r.sy2[`ASC_PIN_SOG];
		st_nxt.prev = {sep_w, st_r.sy2[`ASC_PIN_VS], sog_s, hs_s};
		edges = st_nxt.prev ^ st_r.prev;

		// activity: any edge within the timeout window; a held level is idle
		for (int i = 0; i < 4; i++) begin
			if (edges[i]) begin
				st_nxt.act_cnt[i] = ACT_TIMEOUT_CYC;
			end else if (st_r.act_cnt[i] != 16'h0000) begin
				st_nxt.act_cnt[i] = st_r.act_cnt[i] - 16'h0001;
			end
		end

		// 5 MHz separator tick from the pixel clock
		st_nxt.tick = (st_r.div == 3'h0);
		if (st_r.div == `ASC_SEP_DIV_LAST) begin
			st_nxt.div = 3'h0;
		end else begin
			st_nxt.div = st_r.div + 3'h1;
		end

		// polarity detect: a line sync spends most of its time inactive
		if (hs_s && st_r.pol_cnt != `ASC_POL_MAX) begin
			st_nxt.pol_cnt = st_r.pol_cnt + 8'h01;
		end else if (!hs_s && st_r.pol_cnt != 8'h00) begin
			st_nxt.pol_cnt = st_r.pol_cnt - 8'h01;
		end
		pol_det = (st_r.pol_cnt < `ASC_POL_MID);
		st_nxt.pol = st_r.sync_ctl[`ASC_BIT_HPOL_OVR] ?
			st_r.sync_ctl[`ASC_BIT_HPOL] : pol_det;

		// source and interface selection
		st_nxt.hsrc_sog = pick_src(st_r.sync_ctl[`ASC_BIT_HSRC_OVR],
			st_r.sync_ctl[`ASC_BIT_HSRC_SEL],
			st_r.act_cnt[`ASC_PIN_HS] != 16'h0000,
			st_r.act_cnt[`ASC_PIN_SOG] != 16'h0000);
		st_nxt.vsrc_sep = pick_src(st_r.sync_ctl[`ASC_BIT_VSRC_OVR],
			st_r.sync_ctl[`ASC_BIT_VSRC_SEL],
			st_r.act_cnt[`ASC_PIN_VS] != 16'h0000,
			st_r.act_cnt[`ASC_PIN_SEP] != 16'h0000);
		st_nxt.if_dig = pick_src(st_r.slicer[`ASC_BIT_IF_OVR],
			st_r.slicer[`ASC_BIT_IF_SEL],
			(st_r.act_cnt[`ASC_PIN_HS] | st_r.act_cnt[`ASC_PIN_SOG])
				!= 16'h0000,
			st_r.sy2[`ASC_PIN_DIG]);

		// normalise to active high: the chosen edge leads, the other trails
		norm = st_r.hsrc_sog ? sog_s : (st_r.pol ? hs_s : ~hs_s);
		st_nxt.norm_prev = norm;
		// a wrong polarity only moves the trailing edge, so clamp shifts
		trail = st_r.norm_prev & ~norm;

		// output pulse: starts on feedback, ends width minus one later
		load = (st_r.pw > 8'h01) ? st_r.pw - 8'h01 : 8'h01;
		if (pll_fb_in) begin
			st_nxt.hs_act = 1'b1;
			st_nxt.hs_cnt = load;
		end else if (st_r.hs_act) begin
			if (st_r.hs_cnt <= 8'h01) begin
				st_nxt.hs_act = 1'b0;
			end else begin
				st_nxt.hs_cnt = st_r.hs_cnt - 8'h01;
			end
		end
		st_nxt.hs_o = st_nxt.hs_act ^
			st_r.sync_ctl[`ASC_BIT_HOUT_POL];
		st_nxt.sog_o = sog_s ^ st_r.sync_ctl[`ASC_BIT_HOUT_POL];
		st_nxt.vs_o = (st_r.vsrc_sep ? sep_w : st_r.sy2[`ASC_PIN_VS]) ^
			~st_r.sync_ctl[`ASC_BIT_VOUT_POL];

		// internal clamp, timed from the trailing edge
		case (st_r.clamp_st)
			ASC_CL_IDLE: begin
				st_nxt.clamp = 1'b0;
				if (trail && !st_r.clamp_ctl[`ASC_BIT_CLAMP_OFF] &&
					clamp_placement_in != 8'h00) begin
					st_nxt.clamp_st  = ASC_CL_WAIT;
					st_nxt.clamp_cnt = clamp_placement_in;
				end
			end
			ASC_CL_WAIT: begin
				if (st_r.clamp_cnt <= 8'h01) begin
					st_nxt.clamp_st  = (clamp_duration_in == 8'h00) ?
						ASC_CL_IDLE : ASC_CL_ON;
					st_nxt.clamp     = (clamp_duration_in != 8'h00);
					st_nxt.clamp_cnt = clamp_duration_in;
				end else begin
					st_nxt.clamp_cnt = st_r.clamp_cnt - 8'h01;
				end
			end
			ASC_CL_ON: begin
				if (st_r.clamp_cnt <= 8'h01) begin
					st_nxt.clamp_st = ASC_CL_IDLE;
					st_nxt.clamp    = 1'b0;
				end else begin
					st_nxt.clamp_cnt = st_r.clamp_cnt - 8'h01;
				end
			end
			default: begin
				st_nxt.clamp_st = ASC_CL_IDLE;
				st_nxt.clamp    = 1'b0;
			end
		endcase
		// disabling stops a clamp in flight
		if (st_r.clamp_ctl[`ASC_BIT_CLAMP_OFF]) begin
			st_nxt.clamp_st = ASC_CL_IDLE;
			st_nxt.clamp    = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_r           <= '0;
			st_r.pw        <= `ASC_RST_PW;
			st_r.gain_r    <= `ASC_RST_GAIN;
			st_r.gain_g    <= `ASC_RST_GAIN;
			st_r.gain_b    <= `ASC_RST_GAIN;
			st_r.ofs_r     <= `ASC_RST_OFS;
			st_r.ofs_g     <= `ASC_RST_OFS;
			st_r.ofs_b     <= `ASC_RST_OFS;
			st_r.sep_thr   <= `ASC_RST_SEP_THR;
			st_r.slicer    <= `ASC_RST_SLICER;
			st_r.sync_ctl  <= `ASC_RST_SYNC_CTL;
			st_r.clamp_ctl <= `ASC_RST_CLAMP_CTL;
			st_r.pol_cnt   <= `ASC_POL_MID;
			st_r.pol       <= 1'b1;
			st_r.vs_o      <= 1'b1;
			st_r.clamp_st  <= ASC_CL_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// the separator filters whichever line sync source is in use
	assign sep_in_w = st_r.norm_prev;

	assign reg_rdata_out            = st_r.rdata;
	assign hsync_out                = st_r.hs_o;
	assign sync_on_green_out        = st_r.sog_o;
	assign vsync_out                = st_r.vs_o;
	assign clamp_out                = st_r.clamp;
	assign interface_digital_out    = st_r.if_dig;
	assign hsync_src_sog_out        = st_r.hsrc_sog;
	assign vsync_src_sep_out        = st_r.vsrc_sep;
	assign line_sync_polarity_out   = st_r.pol;
	assign red_channel_gain_out     = st_r.gain_r;
	assign green_channel_gain_out   = st_r.gain_g;
	assign blue_channel_gain_out    = st_r.gain_b;
	assign red_channel_offset_out   =
		st_r.ofs_r[`ASC_OFS_MSB:`ASC_OFS_LSB];
	assign green_channel_offset_out =
		st_r.ofs_g[`ASC_OFS_MSB:`ASC_OFS_LSB];
	assign blue_channel_offset_out  =
		st_r.ofs_b[`ASC_OFS_MSB:`ASC_OFS_LSB];
	assign slicer_threshold_out     =
		st_r.slicer[`ASC_SLICER_MSB:`ASC_SLICER_LSB];
endmodule // asc_regs

// ==== sim/asc_src_model.sv ====
// graphics source model: periodic line sync pulses on the hsync pin only
`timescale 1ns/1ps
module asc_src_model #(
	parameter int PERIOD = 20,
	parameter int WIDTH  = 3
) (
	input  wire logic sys_clk_in,
	input  wire logic en_in,
	output logic      hsync_out,
	output logic      sync_on_green_out,
	output logic      vsync_out
);
	int cnt = 0;
	// idle pins sit low so no activity is seen while disabled
	initial begin
		hsync_out = 1'b0;
		sync_on_green_out = 1'b0;
		vsync_out = 1'b0;
	end
	always @(posedge sys_clk_in) begin
		cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
		hsync_out <= #3 en_in && (cnt < WIDTH);
	end
endmodule // asc_src_model

// ==== sim/asc_regs_checker.sv ====
// concurrent checks on the analog sync register bank ports
`timescale 1ns/1ps
module asc_regs_checker (
	input wire logic       sys_clk_in,
	input wire logic       rst_in,
	input wire logic       reg_wr_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic       pll_fb_in,
	input wire logic       hsync_out,
	input wire logic       clamp_out,
	input wire logic       interface_digital_out,
	input wire logic       hsync_src_sog_out,
	input wire logic       vsync_src_sep_out,
	input wire logic       line_sync_polarity_out,
	input wire logic [7:0] red_channel_gain_out,
	input wire logic [6:0] red_channel_offset_out,
	input wire logic [4:0] slicer_threshold_out
);
	logic [7:0] pw_r;
	logic [7:0] c0f_r;
	logic [7:0] c10_r;
	logic [7:0] c11_r;
	logic [3:0] quiet_r;
	logic       hs_act;
	default clocking @(posedge sys_clk_in);
	endclocking
	default disable iff (rst_in);
	assign hs_act = hsync_out ^ c10_r[5];
	// shadow control bits; quiet_r lets a selection settle after a write
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pw_r <= 8'h20;
			c0f_r <= 8'h78;
			c10_r <= 8'h40;
			c11_r <= 8'h08;
			quiet_r <= 4'h0;
		end else if (reg_wr_in) begin
			quiet_r <= 4'h0;
			case (reg_addr_in)
				8'h07: pw_r <= reg_wdata_in;
				8'h0F: c0f_r <= reg_wdata_in;
				8'h10: c10_r <= reg_wdata_in;
				8'h11: c11_r <= reg_wdata_in;
				default: ;
			endcase
		end else if (quiet_r != 4'hF) begin
			quiet_r <= quiet_r + 4'h1;
		end
	end
	a_gain_write: assert property (
		reg_wr_in && reg_addr_in == 8'h08 |=>
		red_channel_gain_out == $past(reg_wdata_in))
		else $error("gain write lost");
	a_offset_field: assert property (
		reg_wr_in && reg_addr_in == 8'h0B |=>
		red_channel_offset_out == $past(reg_wdata_in[7:1]))
		else $error("offset field wrong");
	a_slicer_field: assert property (
		reg_wr_in && reg_addr_in == 8'h0F |=>
		slicer_threshold_out == $past(reg_wdata_in[7:3]))
		else $error("slicer field wrong");
	a_iface_force: assert property (
		quiet_r > 4'h4 && c0f_r[2] |-> interface_digital_out == c0f_r[1])
		else $error("interface override ignored");
	a_hsrc_force: assert property (
		quiet_r > 4'h4 && c10_r[4] |-> hsync_src_sog_out == c10_r[3])
		else $error("line sync source override ignored");
	a_vsrc_force: assert property (
		quiet_r > 4'h4 && c10_r[1] |-> vsync_src_sep_out == c10_r[0])
		else $error("frame sync source override ignored");
	a_pol_force: assert property (
		quiet_r > 4'h4 && c10_r[7] |-> line_sync_polarity_out == c10_r[6])
		else $error("polarity override ignored");
	a_hs_lead: assert property (
		pll_fb_in && quiet_r != 4'h0 |=> hs_act)
		else $error("line sync output did not start");
	a_hs_width: assert property (
		pll_fb_in && quiet_r != 4'h0 && pw_r == 8'h05 |=>
		hs_act [*4] ##1 !hs_act)
		else $error("line sync output width wrong");
	a_clamp_off: assert property (
		quiet_r > 4'h2 && c11_r[7] |-> !clamp_out)
		else $error("clamp active while disabled");
endmodule // asc_regs_checker

bind asc_regs asc_regs_checker i_asc_regs_checker (.*);

// ==== sim/asc_regs_tb_top.sv ====
// self-checking bench for the analog sync register bank
`timescale 1ns/1ps
module asc_regs_tb_top;
	logic       sys_clk_in = 1'b0;
	logic       rst_in = 1'b1;
	logic       reg_wr_in = 1'b0;
	logic       reg_rd_in = 1'b0;
	logic       pll_fb_in = 1'b0;
	logic       digital_detect_in = 1'b0;
	logic       src_en = 1'b0;
	logic [7:0] reg_addr_in = 8'h00;
	logic [7:0] reg_wdata_in = 8'h00;
	logic [7:0] clamp_placement_in = 8'h03;
	logic [7:0] clamp_duration_in = 8'h04;
	logic [7:0] reg_rdata_out, red_channel_gain_out, green_channel_gain_out;
	logic [7:0] blue_channel_gain_out;
	logic [6:0] red_channel_offset_out, green_channel_offset_out;
	logic [6:0] blue_channel_offset_out;
	logic [4:0] slicer_threshold_out;
	logic       hsync_in, sync_on_green_in, vsync_in, hsync_out, vsync_out;
	logic       sync_on_green_out, clamp_out, interface_digital_out;
	logic       hsync_src_sog_out, vsync_src_sep_out, line_sync_polarity_out;
	int         err_total = 0;
	int         n_checks = 0;
	int         cyc = 0;
	int         k;
	int         n;
	logic [7:0] rst_tab [11] = '{8'h20, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80,
		8'h80, 8'h20, 8'h78, 8'h40, 8'h08};

	always #20 sys_clk_in = ~sys_clk_in;

	asc_regs #(.ACT_TIMEOUT_CYC(16'd64)) i_asc_regs (.*);
	asc_src_model i_asc_src_model (
		.sys_clk_in       (sys_clk_in),
		.en_in            (src_en),
		.hsync_out        (hsync_in),
		.sync_on_green_out(sync_on_green_in),
		.vsync_out        (vsync_in)
	);

	function automatic logic [7:0] pat(input int i);
		return 8'(8'h35 + 17 * i);
	endfunction
	task automatic step(input int c);
		repeat (c) begin
			@(posedge sys_clk_in);
			#1;
		end
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] e);
		n_checks++;
		if (got !== e) begin
			err_total++;
			$display("[ERR] %0t got %h expected %h", $time, got, e);
		end
	endtask
	// strobes drop for one idle cycle so no strobe is set twice at once
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_wr_in = 1'b1;
		reg_addr_in = a;
		reg_wdata_in = d;
		step(1);
		reg_wr_in = 1'b0;
		step(1);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		reg_rd_in = 1'b1;
		reg_addr_in = a;
		step(1);
		reg_rd_in = 1'b0;
		chk(reg_rdata_out, e);
		step(1);
	endtask
	task automatic clamp_cnt(input logic [7:0] e);
		n = 0;
		step(45);
		repeat (40) begin
			step(1);
			if (clamp_out === 1'b1) n++;
		end
		chk(8'(n), e);
	endtask
	task automatic final_report;
		if (err_total == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	always @(posedge sys_clk_in) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			$display("[ERR] %0t run did not finish", $time);
			final_report();
		end
	end

	initial begin
		repeat (20) @(posedge sys_clk_in);
		#1;
		rst_in = 1'b0;
		for (k = 0; k < 11; k++) begin
			rdchk(8'(7 + k), rst_tab[k]);
		end
		// last pass hits an unmapped offset, which reads back zero
		for (k = 0; k < 12; k++) begin
			wr(8'(7 + k), pat(k));
			rdchk(8'(7 + k), (k < 11) ? pat(k) : 8'h00);
		end
		chk(red_channel_gain_out, pat(1));
		chk(green_channel_gain_out, pat(2));
		chk(blue_channel_gain_out, pat(3));
		chk({1'b0, red_channel_offset_out}, pat(4) >> 1);
		chk({1'b0, green_channel_offset_out}, pat(5) >> 1);
		chk({1'b0, blue_channel_offset_out}, pat(6) >> 1);
		chk({3'b0, slicer_threshold_out}, pat(8) >> 3);
		wr(8'h07, 8'h05);
		for (k = 0; k < 2; k++) begin
			wr(8'h10, 8'(k << 5));
			pll_fb_in = 1'b1;
			step(1);
			pll_fb_in = 1'b0;
			n = 0;
			// the pulse is already up after the edge that took the feedback
			repeat (8) begin
				if (hsync_out === !k[0]) n++;
				step(1);
			end
			chk(8'(n), 8'h04);
			chk({7'b0, sync_on_green_out}, 8'(k));
		end
		for (k = 0; k < 2; k++) begin
			wr(8'h0F, 8'(8'h04 | (k << 1)));
			wr(8'h10, 8'(8'h92 | (k * 8'h49)));
			step(4);
			chk({7'b0, interface_digital_out}, 8'(k));
			chk({7'b0, hsync_src_sog_out}, 8'(k));
			chk({7'b0, vsync_src_sep_out}, 8'(k));
			chk({7'b0, line_sync_polarity_out}, 8'(k));
		end
		for (k = 0; k < 2; k++) begin
			wr(8'h10, 8'(8'h92 | (k << 2)));
			step(5);
			chk({7'b0, vsync_out}, 8'(1 - k));
		end
		wr(8'h10, 8'h48);
		wr(8'h0F, 8'h02);
		src_en = 1'b1;
		step(80);
		chk({7'b0, interface_digital_out}, 8'h00);
		chk({7'b0, hsync_src_sog_out}, 8'h00);
		digital_detect_in = 1'b1;
		step(8);
		chk({7'b0, interface_digital_out}, 8'h01);
		wr(8'h0F, 8'h00);
		step(4);
		chk({7'b0, interface_digital_out}, 8'h00);
		src_en = 1'b0;
		step(150);
		chk({7'b0, interface_digital_out}, 8'h01);
		src_en = 1'b1;
		wr(8'h10, 8'hC0);
		wr(8'h11, 8'h00);
		clamp_cnt(8'h08);
		wr(8'h10, 8'h80);
		clamp_cnt(8'h08);
		wr(8'h11, 8'h80);
		clamp_cnt(8'h00);
		// separator as frame sync source: line pulses are filtered out
		wr(8'h10, 8'h87);
		step(30);
		chk({7'b0, vsync_out}, 8'h00);
		src_en = 1'b0;
		wr(8'h0E, 8'h02);
		step(60);
		chk({7'b0, vsync_out}, 8'h01);
		final_report();
	end
endmodule // asc_regs_tb_top
